//--- hdl/mpc_pkg.sv
// package for the motor pin control and fault report block
// assumes a single 200 MHz clock and synchronous active-high reset
package mpc_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SYNC_STAGES = 2;
   // ==========================================================
   // widths
   localparam int unsigned SPEED_W = 16;
   localparam int unsigned DBG_W = 12;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned PWM_W = 12;
   localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;
   localparam logic [PWM_W-1:0] PWM_PERIOD_DEF = 12'hFA0;
   localparam logic [SPEED_W-1:0] DECEL_STEP = 16'h0001;
   // ==========================================================
   // modes
   typedef enum logic [1:0] {
      MPC_WAKE_DUTY,
      MPC_WAKE_FREQ,
      MPC_WAKE_ANALOG,
      MPC_WAKE_RSVD
   } mpc_wake_mode_t;
   typedef enum logic {
      MPC_BRAKE_LOWSIDE,
      MPC_BRAKE_ALIGN
   } mpc_brake_mode_t;
   // six gate enables, three phases high side and low side
   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } mpc_gates_t;
   // override fields written over the serial interface
   typedef struct packed {
      logic brakeOvrEn;
      logic brakeOvrVal;
      logic dirOvrEn;
      logic dirOvrVal;
   } mpc_ovr_t;
   // fault inputs from protection logic
   typedef struct packed {
      logic actionable;
      logic reportOnly;
   } mpc_fault_t;
endpackage

//--- hdl/mpc_sync.sv
// two-flop level synchroniser
// assumes din is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module mpc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;
   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // mpc_sync
`default_nettype wire

//--- hdl/mpc_pulse_gen.sv
// speed feedback pulse generator, phase accumulator
// assumes speed is a rate in accumulator units per clock
`timescale 1ns/1ps
`default_nettype none
module mpc_pulse_gen #(
   parameter int unsigned W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] speed,
   output logic pulse
);
   logic [W-1:0] acc;
   logic [W:0] sum;
   assign sum = {1'b0, acc} + {1'b0, speed};
   // carry out gives a rate proportional to speed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc <= '0;
         pulse <= 1'b0;
      end else begin
         acc <= sum[W-1:0];
         pulse <= sum[W];
      end
   end
endmodule // mpc_pulse_gen
`default_nettype wire

//--- hdl/mpc_core.sv
// pin control and fault reporting of a sensorless motor driver
// assumes pins asynchronous, override fields held stable by host side
`timescale 1ns/1ps
`default_nettype none
module mpc_core #(
   parameter int unsigned RESTART_CYCLES = 64
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic brake_pin,
   input wire logic dir_pin,
   input wire logic bridge_disable_pin,
   input wire logic speed_wake_pin,
   input wire logic [mpc_pkg::SPEED_W-1:0] speed_level_in,
   input wire mpc_pkg::mpc_wake_mode_t wake_mode,
   input wire mpc_pkg::mpc_brake_mode_t brake_mode,
   input wire logic [mpc_pkg::SPEED_W-1:0] brake_speed_threshold,
   input wire mpc_pkg::mpc_ovr_t ovr,
   input wire logic [mpc_pkg::PWM_W-1:0] pwm_period,
   input wire logic [mpc_pkg::SPEED_W-1:0] speed_ramp_step,
   input wire mpc_pkg::mpc_fault_t fault_in,
   input wire logic alarm_enable,
   input wire logic [mpc_pkg::SEL_W-1:0] debug_out_1_select,
   input wire logic [mpc_pkg::SEL_W-1:0] debug_out_2_select,
   output mpc_pkg::mpc_gates_t gates,
   output logic [2:0] phase_order,
   output logic [mpc_pkg::SPEED_W-1:0] speed_cmd,
   output logic in_brake,
   output logic in_coast,
   output logic restart_pulse,
   output logic sleep_req,
   output logic [mpc_pkg::DBG_W-1:0] debug_analog_out_1,
   output logic [mpc_pkg::DBG_W-1:0] debug_analog_out_2,
   output logic speed_pulse_out,
   output logic fault_out_low,
   output logic alarm_out,
   output logic alarm_oe
);
   import mpc_pkg::*;

   // ==========================================================
   // input synchronisers
   logic brakeSync, dirSync, disSync, wakeSync;
   mpc_sync #(.W(4)) uSync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({brake_pin, dir_pin, bridge_disable_pin, speed_wake_pin}),
      .dout({brakeSync, dirSync, disSync, wakeSync})
   );

   // ==========================================================
   // effective inputs after overrides
   logic brakeReq, dirEff;
   // fields come from the host's serial register writes
   // not synchronised: the host holds them stable between writes
   // brake override
   assign brakeReq = ovr.brakeOvrEn ? ovr.brakeOvrVal : brakeSync;
   assign dirEff = ovr.dirOvrEn ? ovr.dirOvrVal : dirSync;

   // ==========================================================
   // speed command decode
   logic [SPEED_W-1:0] periodCnt, highCnt, measDuty, measFreq;
   logic wakeDly;
   logic [SPEED_W-1:0] targetSpeed;
   logic riseEdge;
   assign riseEdge = wakeSync & ~wakeDly;
   // duty: high time per period; frequency: inverted period length count
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wakeDly <= 1'b0;
         periodCnt <= '0;
         highCnt <= '0;
         measDuty <= '0;
         measFreq <= '0;
      end else begin
         wakeDly <= wakeSync;
         if (riseEdge) begin
            measDuty <= highCnt;
            measFreq <= ~periodCnt;
            // the rising cycle is high and opens the next period
            periodCnt <= 16'h0001;
            highCnt <= 16'h0001;
         end else begin
            if (periodCnt != '1) begin
               periodCnt <= periodCnt + 16'h0001;
            end
            if (wakeSync && highCnt != '1) begin
               highCnt <= highCnt + 16'h0001;
            end
         end
      end
   end
   always_comb begin
      unique case (wake_mode)
         MPC_WAKE_DUTY: targetSpeed = measDuty;
         MPC_WAKE_FREQ: targetSpeed = measFreq;
         MPC_WAKE_ANALOG: targetSpeed = speed_level_in;
         default: targetSpeed = '0;
      endcase
   end

   // ==========================================================
   // sleep decision, wake pin or analog speed level
   // sleep from wake pin, or from speed_level_in at zero in analog mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sleep_req <= 1'b0;
      end else if (wake_mode == MPC_WAKE_ANALOG) begin
         sleep_req <= (speed_level_in == '0);
      end else begin
         // pin low through a whole saturated period count means sleep
         sleep_req <= ~wakeSync && (periodCnt == '1);
      end
   end
   // disable pin not used in sleep term above

   // ==========================================================
   // motor state machine
   typedef enum logic [2:0] {
      ST_RUN, ST_DECEL, ST_BRAKE, ST_COAST, ST_RESTART
   } mpc_state_t;
   mpc_state_t state, next_state;
   logic [15:0] restartCnt;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (disSync) next_state = ST_COAST;
            else if (brakeReq) next_state = ST_DECEL;
         end
         ST_DECEL: begin
            if (disSync) next_state = ST_COAST;
            else if (!brakeReq) next_state = ST_RUN;
            else if (speed_cmd <= brake_speed_threshold)
               next_state = ST_BRAKE;
         end
         ST_BRAKE: begin
            if (disSync) next_state = ST_COAST;
            else if (!brakeReq) next_state = ST_RUN;
         end
         ST_COAST: begin
            // coast touches only the bridge and speed_cmd, never sleep
            if (!disSync) next_state = ST_RESTART;
         end
         ST_RESTART: begin
            if (disSync) next_state = ST_COAST;
            else if (restartCnt == 16'(RESTART_CYCLES - 1))
               next_state = ST_RUN;
         end
         default: next_state = ST_COAST;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_COAST;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         restartCnt <= '0;
      end else if (state == ST_RESTART) begin
         restartCnt <= restartCnt + 16'h0001;
      end else begin
         restartCnt <= '0;
      end
   end
   // one cycle only: coast is left on the next edge
   // masked in reset, where the state sits in coast anyway
   assign restart_pulse = (state == ST_COAST) && !disSync && !sys_rst;

   // ==========================================================
   // commanded speed
   // one bit wider so threshold plus step cannot wrap
   logic [SPEED_W:0] decelFloor;
   assign decelFloor = {1'b0, brake_speed_threshold} +
      {1'b0, speed_ramp_step};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         speed_cmd <= SPEED_RST;
      end else begin
         unique case (state)
            ST_DECEL: begin
               if ({1'b0, speed_cmd} > decelFloor) begin
                  speed_cmd <= speed_cmd - speed_ramp_step;
               end else if (speed_cmd > brake_speed_threshold) begin
                  speed_cmd <= brake_speed_threshold;
               end
               // below threshold already: held, never raised to it
            end
            ST_BRAKE, ST_COAST, ST_RESTART: speed_cmd <= '0;
            ST_RUN: speed_cmd <= targetSpeed;
            default: speed_cmd <= '0;
         endcase
      end
   end
   assign in_brake = (state == ST_BRAKE);
   assign in_coast = (state == ST_COAST);

   // ==========================================================
   // phase order and bridge gates
   // commutation order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_order <= 3'b000;
      end else begin
         phase_order <= dirEff ? 3'b001 : 3'b000;
      end
   end
   // phase_order 1 = A,B,C ; 0 = A,C,B
   // gates follow next_state so they switch with the state itself
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gates <= '0;
      end else if (next_state == ST_COAST) begin
         gates <= '0;
      end else if (next_state == ST_BRAKE) begin
         if (brake_mode == MPC_BRAKE_LOWSIDE)
            gates <= '{high: 3'b000, low: 3'b111};
         else
            gates <= '{high: 3'b001, low: 3'b110};
      end else if (speed_cmd == '1) begin
         // full duty, high side held on, no refresh gap
         gates <= '{high: 3'b001, low: 3'b010};
      end else begin
         gates <= '{high: 3'b000, low: 3'b000};
      end
   end

   // ==========================================================
   // debug outputs, refreshed once per PWM period
   logic [PWM_W-1:0] pwmCnt;
   logic pwmWrap;
   // a zero period wraps only every 4096 clocks, so keep it at one or more
   assign pwmWrap = (pwmCnt >= pwm_period - 12'h001);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwmCnt <= '0;
      end else if (pwmWrap) begin
         pwmCnt <= '0;
      end else begin
         pwmCnt <= pwmCnt + 12'h001;
      end
   end
   // wide variables show their top bits only
   function automatic logic [DBG_W-1:0] pick(input logic [SEL_W-1:0] s,
      input logic [SPEED_W-1:0] sp, input logic [SPEED_W-1:0] tg,
      input logic [2:0] st, input logic [2:0] po);
      logic [DBG_W-1:0] v;
      v = '0;
      unique case (s)
         3'h0: v = sp[SPEED_W-1 -: DBG_W];
         3'h1: v = tg[SPEED_W-1 -: DBG_W];
         3'h2: v = {9'h000, st};
         3'h3: v = {9'h000, po};
         default: v = '0;
      endcase
      return v;
   endfunction
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         debug_analog_out_1 <= '0;
         debug_analog_out_2 <= '0;
      end else if (pwmWrap) begin
         debug_analog_out_1 <= pick(debug_out_1_select, speed_cmd,
            targetSpeed, state, phase_order);
         debug_analog_out_2 <= pick(debug_out_2_select, speed_cmd,
            targetSpeed, state, phase_order);
      end
   end

   // ==========================================================
   // speed feedback pulses
   // rate follows speed
   mpc_pulse_gen #(.W(SPEED_W)) uPulse (
      .clk(clk),
      .sys_rst(sys_rst),
      .speed(speed_cmd),
      .pulse(speed_pulse_out)
   );

   // ==========================================================
   // fault and alarm reporting
   // registered so the pins never glitch while faults decode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_out_low <= 1'b1;
         alarm_out <= 1'b0;
         alarm_oe <= 1'b0;
      end else if (alarm_enable) begin
         alarm_out <= fault_in.actionable | fault_in.reportOnly;
         alarm_oe <= 1'b1;
         fault_out_low <= ~fault_in.actionable;
      end else begin
         alarm_out <= 1'b0;
         alarm_oe <= 1'b0;
         fault_out_low <= ~(fault_in.actionable | fault_in.reportOnly);
      end
   end
endmodule // mpc_core
`default_nettype wire

//--- dv/mpc_core_properties.sv
// assertion checker for the pin control block, bound onto mpc_core
// assumes one clock domain and the core's synchronous reset
`timescale 1ns/1ps
`default_nettype none
module mpc_core_properties
   import mpc_pkg::*;
#(
   parameter int unsigned RESTART_CYCLES = 64
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire mpc_pkg::mpc_brake_mode_t brake_mode,
   input wire logic [mpc_pkg::SPEED_W-1:0] brake_speed_threshold,
   input wire mpc_pkg::mpc_ovr_t ovr,
   input wire logic bridge_disable_pin,
   input wire mpc_pkg::mpc_fault_t fault_in,
   input wire logic alarm_enable,
   input wire mpc_pkg::mpc_gates_t gates,
   input wire logic [2:0] phase_order,
   input wire logic [mpc_pkg::SPEED_W-1:0] speed_cmd,
   input wire logic in_brake,
   input wire logic in_coast,
   input wire logic restart_pulse,
   input wire logic speed_pulse_out,
   input wire logic fault_out_low,
   input wire logic alarm_out,
   input wire logic alarm_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // =========================================================
   // sequences
   // overrides held two edges, reset long gone
   sequence settled;
      !$past(sys_rst) && !$past(sys_rst, 2) && ovr == $past(ovr) &&
         ovr == $past(ovr, 2);
   endsequence
   // registered outputs need one clean edge
   sequence afterRun;
      !$past(sys_rst);
   endsequence
   // =========================================================
   // properties
   coast_gates_a: assert property (in_coast |-> gates == '0)
      else $error("gates on in coast");
   brake_gates_a: assert property (in_brake && $past(in_brake) &&
      $stable(brake_mode) |->
      gates == (brake_mode == MPC_BRAKE_ALIGN ? 6'h0E : 6'h07))
      else $error("wrong brake gate pattern");
   brake_entry_a: assert property ($rose(in_brake) |->
      $past(speed_cmd) <= brake_speed_threshold)
      else $error("brake entered above threshold");
   brake_hold_a: assert property (settled ##0
      (ovr.brakeOvrEn && ovr.brakeOvrVal && in_brake &&
      !$past(bridge_disable_pin, 2)) |=> in_brake)
      else $error("brake left while requested");
   dir_ovr_a: assert property (settled ##0 ovr.dirOvrEn |->
      phase_order == {2'h0, ovr.dirOvrVal})
      else $error("direction override ignored");
   report_only_a: assert property (afterRun ##0
      $past(alarm_enable && fault_in.reportOnly && !fault_in.actionable)
      |-> alarm_out && alarm_oe && fault_out_low)
      else $error("report-only fault misrouted");
   actionable_a: assert property (afterRun ##0
      $past(alarm_enable && fault_in.actionable)
      |-> alarm_out && !fault_out_low)
      else $error("actionable fault misrouted");
   alarm_off_a: assert property (afterRun ##0 !$past(alarm_enable)
      |-> !alarm_oe && fault_out_low ==
      !$past(fault_in.actionable || fault_in.reportOnly))
      else $error("disabled alarm misbehaves");
   idle_pulse_a: assert property (speed_cmd == '0 &&
      $past(speed_cmd) == '0 && $past(speed_cmd, 2) == '0
      |-> !speed_pulse_out) else $error("speed pulse at zero speed");
   restart_leave_a: assert property (restart_pulse |=> !in_coast)
      else $error("coast kept after restart");
endmodule // mpc_core_properties
bind mpc_core mpc_core_properties #(.RESTART_CYCLES(RESTART_CYCLES)) props (
   .clk, .sys_rst, .brake_mode, .brake_speed_threshold, .ovr, .fault_in,
   .alarm_enable, .gates, .phase_order, .speed_cmd, .in_brake, .in_coast,
   .restart_pulse, .speed_pulse_out, .fault_out_low, .alarm_out, .alarm_oe,
   .bridge_disable_pin
);
`default_nettype wire

//--- dv/mpc_host_model.sv
// host controller model: drives control pins and override fields
// assumes callers are aligned to the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module mpc_host_model (
   input wire logic clk,
   output logic brake_pin,
   output logic dir_pin,
   output logic bridge_disable_pin,
   output logic speed_wake_pin,
   output mpc_pkg::mpc_ovr_t ovr
);
   import mpc_pkg::*;
   initial begin
      {brake_pin, dir_pin, bridge_disable_pin, speed_wake_pin} = 4'h0;
      ovr = '0;
   end
   // host writes overrides
   // levels change just after an edge, held until the next call
   task automatic drive(input logic [3:0] p, input mpc_ovr_t o);
      @(posedge clk);
      #1;
      {brake_pin, dir_pin, bridge_disable_pin, speed_wake_pin} = p;
      ovr = o;
   endtask
endmodule // mpc_host_model
`default_nettype wire

//--- dv/motor_pin_control_and_fault_report_tb_top.sv
// self-checking bench for the pin control and fault report core
// assumes mpc_core, its package and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module motor_pin_control_and_fault_report_tb_top;
   import mpc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wire logic brake_pin, dir_pin, bridge_disable_pin, speed_wake_pin;
   wire mpc_ovr_t ovr;
   logic [SPEED_W-1:0] speed_level_in = 16'h0800;
   mpc_wake_mode_t wake_mode = MPC_WAKE_ANALOG;
   mpc_brake_mode_t brake_mode = MPC_BRAKE_LOWSIDE;
   logic [SPEED_W-1:0] brake_speed_threshold = 16'h0100;
   logic [PWM_W-1:0] pwm_period = 12'h008;
   logic [SPEED_W-1:0] speed_ramp_step = 16'h0010;
   mpc_fault_t fault_in = '0;
   logic alarm_enable = 1'b0;
   logic [SEL_W-1:0] debug_out_1_select = 3'h3;
   logic [SEL_W-1:0] debug_out_2_select = 3'h5;
   mpc_gates_t gates;
   logic [2:0] phase_order;
   logic [SPEED_W-1:0] speed_cmd;
   logic in_brake, in_coast, restart_pulse, sleep_req, speed_pulse_out;
   logic [DBG_W-1:0] debug_analog_out_1, debug_analog_out_2;
   logic fault_out_low, alarm_out, alarm_oe;
   int miscompares = 0;
   int testsRun = 0;
   int cycles = 0;
   logic dirV = 1'b1;
   // short restart keeps the run brief
   mpc_core #(.RESTART_CYCLES(4)) dut (
      .clk, .sys_rst, .brake_pin, .dir_pin, .bridge_disable_pin,
      .speed_wake_pin, .speed_level_in, .wake_mode, .brake_mode,
      .brake_speed_threshold, .ovr, .pwm_period, .speed_ramp_step,
      .fault_in, .alarm_enable, .debug_out_1_select, .debug_out_2_select,
      .gates, .phase_order, .speed_cmd, .in_brake, .in_coast,
      .restart_pulse, .sleep_req, .debug_analog_out_1, .debug_analog_out_2,
      .speed_pulse_out, .fault_out_low, .alarm_out, .alarm_oe
   );
   mpc_host_model host (
      .clk, .brake_pin, .dir_pin, .bridge_disable_pin, .speed_wake_pin, .ovr
   );
   always #2.5 clk = ~clk;
   // =========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
         input logic [15:0] g);
      testsRun++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic pins(input logic b, input logic x, input mpc_ovr_t o);
      host.drive({b, dirV, x, 1'b1}, o);
   endtask
   task automatic waitOn(ref logic s);
      for (int i = 0; i < 300 && s !== 1'b1; i++) cyc(1);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // =========================================================
   // scenarios
   task automatic tFault();
      logic [2:0] e;
      for (int k = 0; k < 8; k++) begin
         alarm_enable = k[2];
         fault_in = k[1:0];
         cyc(2);
         e = {!(k[2] ? k[1] : |k[1:0]), k[2], k[2] & |k[1:0]};
         chk("fault pins", e, {fault_out_low, alarm_oe, alarm_out & alarm_oe});
      end
      alarm_enable = 1'b0;
      fault_in = '0;
      $display("test fault done");
   endtask
   task automatic tDir();
      for (int d = 0; d < 2; d++) begin
         dirV = d[0];
         pins(1'b0, 1'b0, '0);
         cyc(5);
         chk("dir pin", dirV, phase_order);
         pins(1'b0, 1'b0, {2'h0, 1'b1, !dirV});
         cyc(5);
         chk("dir override", !dirV, phase_order);
      end
      pins(1'b0, 1'b0, '0);
      cyc(5);
      $display("test direction done");
   endtask
   task automatic tDebug();
      cyc(20);
      chk("debug one", dirV, debug_analog_out_1);
      chk("debug two", 12'h000, debug_analog_out_2);
      debug_out_1_select = 3'h7;
      debug_out_2_select = 3'h3;
      cyc(20);
      chk("debug one swap", 12'h000, debug_analog_out_1);
      chk("debug two swap", dirV, debug_analog_out_2);
      $display("test debug done");
   endtask
   task automatic tBrake();
      for (int m = 0; m < 2; m++) begin
         brake_mode = mpc_brake_mode_t'(m);
         cyc(100);
         pins(1'b1, 1'b0, '0);
         waitOn(in_brake);
         chk("brake gates", m ? 12'h00E : 12'h007, gates);
         cyc(40);
         chk("brake held", 12'h001, in_brake);
         pins(1'b0, 1'b0, '0);
         cyc(6);
         chk("brake left", 12'h000, in_brake);
      end
      // override asserts brake, then masks a high pin
      pins(1'b0, 1'b0, 4'hC);
      waitOn(in_brake);
      cyc(20);
      chk("override brake", 12'h001, in_brake);
      pins(1'b1, 1'b0, 4'h8);
      cyc(8);
      chk("override release", 12'h000, in_brake);
      pins(1'b0, 1'b0, '0);
      $display("test brake done");
   endtask
   task automatic tCoast();
      cyc(50);
      pins(1'b0, 1'b1, '0);
      cyc(4);
      chk("coast", 12'h001, in_coast);
      chk("coast gates", 12'h000, gates);
      cyc(50);
      chk("no sleep", 16'h0000, sleep_req);
      pins(1'b0, 1'b0, '0);
      waitOn(restart_pulse);
      chk("restart", 12'h001, restart_pulse);
      cyc(20);
      chk("running", 12'h000, in_coast);
      $display("test coast done");
   endtask
   task automatic tSpeed();
      int n;
      n = 0;
      // wake pin high 3 clocks in every 8
      wake_mode = MPC_WAKE_DUTY;
      for (int i = 0; i < 40; i++) begin
         host.drive({1'b0, dirV, 1'b0, (i % 8) < 3}, '0);
      end
      cyc(1);
      chk("duty speed", 16'h0003, speed_cmd);
      wake_mode = MPC_WAKE_FREQ;
      cyc(2);
      chk("freq speed", 16'hFFF7, speed_cmd);
      pins(1'b0, 1'b0, '0);
      wake_mode = MPC_WAKE_ANALOG;
      speed_level_in = 16'h0000;
      cyc(2);
      chk("sleep", 16'h0001, sleep_req);
      speed_level_in = 16'h0800;
      cyc(2);
      chk("awake", 16'h0000, sleep_req);
      for (int i = 0; i < 256; i++) begin
         cyc(1);
         n += speed_pulse_out;
      end
      chk("pulse count", 16'h0008, 16'(n));
      speed_level_in = 16'hFFFF;
      cyc(3);
      for (int i = 0; i < 4; i++) begin
         cyc(1);
         chk("full duty high", 16'h0001, gates.high != 3'h0);
      end
      speed_level_in = 16'h0800;
      debug_out_1_select = 3'h0;
      cyc(20);
      chk("debug speed", 16'h0080, debug_analog_out_1);
      $display("test speed done");
   endtask
   // =========================================================
   // run
   always @(posedge clk) begin
      cycles++;
      // whole run needs about 1300 cycles
      if (cycles == 6000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      pins(1'b0, 1'b0, '0);
      cyc(50);
      tFault();
      tDir();
      tDebug();
      tBrake();
      tCoast();
      tSpeed();
      summarize();
   end
endmodule // motor_pin_control_and_fault_report_tb_top
`default_nettype wire
